/* File: verilog/sprb_pkg.sv */
/*
  sprb_pkg: constants shared by the serial port register bank.
  Assumes an 8-bit register map of 18 entries at 0x00..0x11 behind a 13-bit address.
*/
package sprb_pkg;
  localparam int REG_COUNT = 18;
  localparam int ADDR_W = 13;

  // command word layout
  localparam int CMD_BITS = 16;
  localparam int CMD_RW_BIT = 15;
  localparam int CMD_LEN_HI = 14;
  localparam int CMD_LEN_LO = 13;
  localparam logic [3:0] CMD_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_CONFIG = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_READBACK_SELECT = 13'h0004;
  localparam logic [ADDR_W-1:0] ADDR_BUFFER_TRIGGER = 13'h0005;
  localparam logic [ADDR_W-1:0] ADDR_PUMP_CURRENT = 13'h000a;
  localparam logic [ADDR_W-1:0] ADDR_PUMP_OPTIONS = 13'h000b;
  localparam logic [ADDR_W-1:0] ADDR_PUMP_CLOCK_DIV = 13'h000c;
  localparam logic [ADDR_W-1:0] ADDR_BACKLASH_LOCK = 13'h000d;
  localparam logic [ADDR_W-1:0] ADDR_OSC_CAL = 13'h000e;
  localparam logic [ADDR_W-1:0] ADDR_OSC_LEVEL = 13'h000f;
  localparam logic [ADDR_W-1:0] ADDR_OSC_BAND = 13'h0010;

  // field positions
  localparam int LSB_FIRST_BIT_A = 6;
  localparam int LSB_FIRST_BIT_B = 1;
  localparam logic [7:0] SOFT_RESET_MASK = 8'h24;
  localparam int READBACK_BIT = 0;
  localparam int TRIGGER_BIT = 0;
  localparam int CALIBRATE_BIT = 7;

  // the pump current default is not given; plain value
  localparam logic [7:0] PUMP_CURRENT_DEFAULT = 8'h00;

  // reset values, index 17 down to 0
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h00, 8'h80, 8'h80, 8'h70, 8'h00, 8'h00, 8'h30, PUMP_CURRENT_DEFAULT,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18};

  // writable bits, index 17 down to 0; all others ignore writes
  localparam logic [REG_COUNT-1:0][7:0] REG_WMASK = {
    8'h00, 8'hfe, 8'hfc, 8'hff, 8'hc1, 8'h07, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h66};

  typedef enum logic [1:0] {
    SPRB_CMD = 2'b01,
    SPRB_DATA = 2'b10
  } sprb_phase_e;
endpackage

/* File: verilog/sprb_sync.sv */
/*
  sprb_sync: two-flop synchroniser for one asynchronous level.
  Assumes the input is a pin outside the clock domain.
*/
`timescale 1ns/10ps
module sprb_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic resetValue,
  input wire logic asyncIn,
  output logic syncOut
);
  typedef struct packed {
    logic firstStage;
    logic secondStage;
  } sprb_sync_s;

  sprb_sync_s syncReg, syncNext;

  // stages hold the pin xor its idle level, so reset loads plain zeros
  always_comb begin
    syncNext = syncReg;
    syncNext.firstStage = asyncIn ^ resetValue;
    syncNext.secondStage = syncReg.firstStage; // only reader of the first stage
  end

  // both stages in one register; reset takes constants only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  // idle level comes back out of reset, so no false edge follows release
  assign syncOut = syncReg.secondStage ^ resetValue;
endmodule

/* File: verilog/sprb_serial_port_register_bank.sv */
/*
  sprb_serial_port_register_bank: slave of a 3-wire serial control port with buffered registers 0x00..0x11.
  Assumes sclk, csN and sdioIn are asynchronous pins far slower than clock; sdio wire is resolved outside.
*/
// Overview of operation
// - every transaction opens with a 16-bit command of direction, length code and 13-bit address.
// - a top bit of 0 writes the following bytes into the buffer, a top bit of 1 shifts registers out.
// - length codes 00, 01, 10 mean one, two, three bytes and 11 streams until select rises.
// - the address steps down per byte in msb-first order and up per byte in lsb-first order.
// - writes land in buffers made active by an update, and reads return buffers only when readback is set.
// - self-clearing bits are active high and return to 0 when their task has run.
// - read data on the data line changes on falling edges of the shift clock.
// - the pump current is an 8-bit field of about 3.5 uA per step.
`timescale 1ns/10ps
module sprb_serial_port_register_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic [7:0] pumpCurrent,
  output logic [7:0] pumpOptions,
  output logic [7:0] pumpClockDiv,
  output logic [7:0] backlashLock,
  output logic [7:0] oscCalControl,
  output logic [7:0] oscLevel,
  output logic [7:0] oscBand,
  output logic calibrateStart,
  output logic lsbFirstActive
);
  import sprb_pkg::*;

  typedef struct packed {
    sprb_phase_e phase;
    logic sclkPrev;
    logic csPrev;
    logic [15:0] shiftIn;
    logic [3:0] bitCnt;
    logic isRead;
    logic [1:0] lenCode;
    logic [1:0] byteCnt;
    logic done;
    logic [ADDR_W-1:0] addr;
    logic [7:0] txByte;
    logic sdioOut;
    logic sdioOe;
    logic calPulse;
    logic [REG_COUNT-1:0][7:0] bufRegs;
    logic [REG_COUNT-1:0][7:0] actRegs;
  } sprb_state_s;

  sprb_state_s stReg, stNext;
  logic sclkS, csS, dinS;
  logic sclkRise, sclkFall, csRise, lsbFirst, byteEnd, cmdEnd;

  sprb_sync syncSclk (.clock(clock), .rst(rst), .resetValue(1'b0), .asyncIn(sclk), .syncOut(sclkS));
  sprb_sync syncCs (.clock(clock), .rst(rst), .resetValue(1'b1), .asyncIn(csN), .syncOut(csS));
  sprb_sync syncDin (.clock(clock), .rst(rst), .resetValue(1'b0), .asyncIn(sdioIn), .syncOut(dinS));

  // edges seen on the synchronised pins
  assign sclkRise = sclkS & ~stReg.sclkPrev;
  assign sclkFall = ~sclkS & stReg.sclkPrev;
  assign csRise = csS & ~stReg.csPrev;
  assign lsbFirst = stReg.actRegs[0][LSB_FIRST_BIT_A] | stReg.actRegs[0][LSB_FIRST_BIT_B];
  assign cmdEnd = ~csS & sclkRise & (stReg.phase == SPRB_CMD) & (stReg.bitCnt == CMD_LAST_BIT);
  assign byteEnd = ~csS & sclkRise & (stReg.phase == SPRB_DATA) & ~stReg.done
    & (stReg.bitCnt[2:0] == BYTE_LAST_BIT);

  // register read view: active unless readback asks for the buffers
  function automatic logic [7:0] readReg(input sprb_state_s s, input logic [ADDR_W-1:0] a);
    logic [7:0] val;
    val = 8'h00;
    if (a < ADDR_W'(REG_COUNT)) begin
      if (s.actRegs[ADDR_READBACK_SELECT][READBACK_BIT]) begin
        val = s.bufRegs[a[4:0]];
      end else begin
        val = s.actRegs[a[4:0]];
      end
    end
    return val;
  endfunction

  always_comb begin
    logic [15:0] sh;
    logic [7:0] wdata;
    logic [ADDR_W-1:0] nextAddr;
    sh = stReg.shiftIn;
    wdata = 8'h00;
    nextAddr = stReg.addr;
    stNext = stReg;
    stNext.sclkPrev = sclkS;
    stNext.csPrev = csS;
    stNext.calPulse = 1'b0;
    // calibrate bit self-clears one cycle after it becomes active
    if (stReg.actRegs[ADDR_OSC_CAL][CALIBRATE_BIT]) begin
      stNext.calPulse = 1'b1;
      stNext.actRegs[ADDR_OSC_CAL][CALIBRATE_BIT] = 1'b0;
      stNext.bufRegs[ADDR_OSC_CAL][CALIBRATE_BIT] = 1'b0;
    end
    if (csS) begin
      // select high: release the line; abort on non-byte boundary, else stall or end
      stNext.sdioOe = 1'b0;
      if (csRise) begin
        if (stReg.bitCnt[2:0] != 3'h0 || (stReg.phase == SPRB_DATA
            && (stReg.lenCode == LEN_STREAM || stReg.done))) begin
          stNext.phase = SPRB_CMD;
          stNext.bitCnt = 4'h0;
          stNext.done = 1'b0;
          stNext.byteCnt = 2'h0;
        end
      end
    end else if (sclkRise) begin
      // capture on rising shift clock edges
      if (lsbFirst) begin
        sh = (stReg.phase == SPRB_CMD) ? {dinS, stReg.shiftIn[15:1]} : {8'h00, dinS, stReg.shiftIn[7:1]};
      end else begin
        sh = {stReg.shiftIn[14:0], dinS};
      end
      if (stReg.phase == SPRB_CMD) begin
        stNext.shiftIn = sh;
        stNext.bitCnt = stReg.bitCnt + 4'h1;
        if (cmdEnd) begin
          stNext.isRead = sh[CMD_RW_BIT];
          stNext.lenCode = sh[CMD_LEN_HI:CMD_LEN_LO];
          stNext.addr = sh[ADDR_W-1:0];
          stNext.phase = SPRB_DATA;
          stNext.bitCnt = 4'h0;
          stNext.byteCnt = 2'h0;
          stNext.done = 1'b0;
          stNext.txByte = readReg(stReg, sh[ADDR_W-1:0]);
        end
      end else if (!stReg.done) begin
        stNext.shiftIn = sh;
        stNext.bitCnt = {1'b0, stReg.bitCnt[2:0] + 3'h1};
        if (byteEnd) begin
          wdata = sh[7:0]; // both orders assemble the byte in the low half
          nextAddr = lsbFirst ? stReg.addr + 13'h0001 : stReg.addr - 13'h0001;
          stNext.addr = nextAddr;
          stNext.bitCnt = 4'h0;
          stNext.byteCnt = stReg.byteCnt + 2'h1;
          stNext.done = (stReg.lenCode != LEN_STREAM) && (stReg.byteCnt == stReg.lenCode);
          if (!stReg.isRead && stReg.addr < ADDR_W'(REG_COUNT)) begin
            stNext.bufRegs[stReg.addr[4:0]] = (stReg.bufRegs[stReg.addr[4:0]] & ~REG_WMASK[stReg.addr[4:0]])
              | (wdata & REG_WMASK[stReg.addr[4:0]]);
            if (stReg.addr == ADDR_SERIAL_CONFIG && (wdata & SOFT_RESET_MASK) != 8'h00) begin
              stNext.bufRegs = REG_RESET;
              stNext.actRegs = REG_RESET;
            end else if (stReg.addr == ADDR_BUFFER_TRIGGER && wdata[TRIGGER_BIT]) begin
              stNext.bufRegs[ADDR_BUFFER_TRIGGER][TRIGGER_BIT] = 1'b0;
              stNext.actRegs = stNext.bufRegs;
              stNext.bufRegs[ADDR_OSC_CAL][CALIBRATE_BIT] = 1'b0;
            end
          end
          if (stReg.isRead) begin
            stNext.txByte = readReg(stReg, nextAddr);
          end
        end
      end
    end else if (sclkFall && stReg.phase == SPRB_DATA && stReg.isRead && !stReg.done) begin
      // read data changes only on falling edges
      stNext.sdioOe = 1'b1;
      if (lsbFirst) begin
        stNext.sdioOut = stReg.txByte[0];
        stNext.txByte = {1'b0, stReg.txByte[7:1]};
      end else begin
        stNext.sdioOut = stReg.txByte[7];
        stNext.txByte = {stReg.txByte[6:0], 1'b0};
      end
    end
  end

  // whole state in one register; reset takes constants only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stReg <= '{phase: SPRB_CMD, sclkPrev: 1'b0, csPrev: 1'b1, shiftIn: 16'h0000, bitCnt: 4'h0,
        isRead: 1'b0, lenCode: 2'h0, byteCnt: 2'h0, done: 1'b0, addr: 13'h0000, txByte: 8'h00,
        sdioOut: 1'b0, sdioOe: 1'b0, calPulse: 1'b0, bufRegs: REG_RESET, actRegs: REG_RESET};
    end else begin
      stReg <= stNext;
    end
  end

  // outputs straight from the state register; register fields from the active registers
  assign sdioOut = stReg.sdioOut;
  assign sdioOe = stReg.sdioOe;
  assign pumpCurrent = stReg.actRegs[ADDR_PUMP_CURRENT];
  assign pumpOptions = stReg.actRegs[ADDR_PUMP_OPTIONS];
  assign pumpClockDiv = stReg.actRegs[ADDR_PUMP_CLOCK_DIV];
  assign backlashLock = stReg.actRegs[ADDR_BACKLASH_LOCK];
  assign oscCalControl = stReg.actRegs[ADDR_OSC_CAL];
  assign oscLevel = stReg.actRegs[ADDR_OSC_LEVEL];
  assign oscBand = stReg.actRegs[ADDR_OSC_BAND];
  assign calibrateStart = stReg.calPulse;
  assign lsbFirstActive = lsbFirst;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seqCmdDone;
    cmdEnd;
  endsequence
  sequence seqWriteByte;
    byteEnd && !stReg.isRead && stReg.addr == ADDR_BUFFER_TRIGGER && stNext.shiftIn[TRIGGER_BIT];
  endsequence

  chk_cmd_decode: assert property (seqCmdDone |=> stReg.phase == SPRB_DATA && stReg.bitCnt == 4'h0
    && stReg.isRead == $past(stNext.shiftIn[CMD_RW_BIT])) else $error("command word misdecoded");
  chk_read_enable: assert property (sdioOe |-> stReg.isRead && stReg.phase == SPRB_DATA)
    else $error("data line driven outside a read");
  chk_length_stop: assert property (byteEnd && stReg.lenCode != LEN_STREAM && stReg.byteCnt == stReg.lenCode
    |=> stReg.done) else $error("transfer did not stop at its length");
  chk_addr_step: assert property (byteEnd |=> stReg.addr ==
    ($past(lsbFirst) ? $past(stReg.addr) + 13'h0001 : $past(stReg.addr) - 13'h0001)) else $error("address step wrong");
  chk_update_copy: assert property (seqWriteByte |=> stReg.actRegs[ADDR_PUMP_CURRENT]
    == $past(stReg.bufRegs[ADDR_PUMP_CURRENT])) else $error("update did not copy buffers");
  chk_cal_clear: assert property (stReg.actRegs[ADDR_OSC_CAL][CALIBRATE_BIT] |=> calibrateStart
    ##1 !stReg.actRegs[ADDR_OSC_CAL][CALIBRATE_BIT]) else $error("calibrate bit did not clear");
  chk_fall_change: assert property ($changed(sdioOut) |-> $past(sclkFall))
    else $error("read data changed off a falling edge");
  chk_pump_field: assert property ($changed(pumpCurrent) |-> $past(byteEnd && !stReg.isRead
    && (stReg.addr == ADDR_BUFFER_TRIGGER || stReg.addr == ADDR_SERIAL_CONFIG)))
    else $error("pump current moved without update");
  chk_unused_zero: assert property ((stReg.bufRegs[ADDR_PUMP_CLOCK_DIV] & ~REG_WMASK[ADDR_PUMP_CLOCK_DIV]) == 8'h00
    && stReg.bufRegs[1] == 8'h00) else $error("unused bits not zero");
endmodule

/* File: testbench/sprb_host_model.sv */
/*
  sprb_host_model: host controller driving the 3-wire serial control port.
  Assumes clock is the bench clock; sdio is the resolved data wire.
*/
`timescale 1ns/10ps
module sprb_host_model (
  input wire logic clock,
  input wire logic sdio,
  output logic sclk,
  output logic csN,
  output logic hostBit,
  output logic hostOe
);
  // link idles with shift clock still and select high
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostBit = 1'b0;
    hostOe = 1'b0;
  end

  // bit set up in low phase, taken at rise, read bit sampled late in high phase
  task automatic bitCycle(input logic b, output logic r);
    hostBit <= b;
    repeat (4) @(posedge clock);
    sclk <= 1'b1;
    repeat (4) @(posedge clock);
    r = sdio;
    sclk <= 1'b0;
  endtask

  // one framed transaction: command then n bytes, msb- or lsb-first
  task automatic xfer(input logic lsb, input logic [15:0] cmd, input int n, input logic [31:0] wr,
                      output logic [31:0] rd);
    logic r;
    int i;
    int p;
    rd = 32'h0;
    @(posedge clock);
    csN <= 1'b0;
    hostOe <= 1'b1;
    for (i = 0; i < 16; i++) begin
      bitCycle(cmd[lsb ? i : 15 - i], r);
    end
    if (cmd[15]) begin
      hostOe <= 1'b0;
    end
    for (i = 0; i < 8 * n; i++) begin
      p = 24 - 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
      bitCycle(wr[p], r);
      rd[p] = r;
    end
    repeat (4) @(posedge clock);
    csN <= 1'b1;
    hostOe <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule

/* File: testbench/sprb_serial_port_register_bank_tb.sv */
/*
  sprb_serial_port_register_bank_tb: self-checking bench for the serial register bank.
  Assumes the host model drives the link; released data wire shows the inverse of the last bit.
*/
`timescale 1ns/10ps
module sprb_serial_port_register_bank_tb;
  logic clock, rst, sclk, csN, hostBit, hostOe, sdio, sdioOut, sdioOe, calibrateStart, lsbFirstActive, lsbMode;
  logic [7:0] pumpCurrent, pumpOptions, pumpClockDiv, backlashLock, oscCalControl, oscLevel, oscBand;
  logic [31:0] r;
  int failCount = 0;
  int samplesChecked = 0;
  int calCount = 0;

  // wire resolution; nobody driving gives the inverse of the host bit
  assign sdio = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);

  sprb_serial_port_register_bank sprb_serial_port_register_bank_inst (.clock(clock), .rst(rst), .sclk(sclk),
    .csN(csN), .sdioIn(sdio), .sdioOut(sdioOut), .sdioOe(sdioOe), .pumpCurrent(pumpCurrent),
    .pumpOptions(pumpOptions), .pumpClockDiv(pumpClockDiv), .backlashLock(backlashLock),
    .oscCalControl(oscCalControl), .oscLevel(oscLevel), .oscBand(oscBand), .calibrateStart(calibrateStart),
    .lsbFirstActive(lsbFirstActive));
  sprb_host_model sprb_host_model_inst (.clock(clock), .sdio(sdio), .sclk(sclk), .csN(csN), .hostBit(hostBit),
    .hostOe(hostOe));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // count calibrate pulses seen
  always @(posedge clock) begin
    if (calibrateStart === 1'b1) calCount++;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [1:0] len, input logic [31:0] d);
    sprb_host_model_inst.xfer(lsbMode, {1'b0, len, a}, int'(len) + 1, d, r);
  endtask
  task automatic rd(input logic [12:0] a, input logic [1:0] len, input int n);
    sprb_host_model_inst.xfer(lsbMode, {1'b1, len, a}, n, 32'h0, r);
  endtask
  task automatic upd;
    wr(13'h5, 2'h0, 32'h01000000);
  endtask

  task automatic tDefaults;
    cmp8(pumpOptions, 8'h30);
    cmp8(oscCalControl, 8'h70);
    cmp8({oscLevel ^ 8'h80} | oscBand ^ 8'h80 | pumpCurrent | backlashLock, 8'h00);
    rd(13'h0, 2'h0, 1);
    cmp8(r[31:24], 8'h18);
  endtask
  task automatic tBuffered;
    wr(13'ha, 2'h0, 32'ha5000000);
    cmp8(pumpCurrent, 8'h00);
    upd();
    cmp8(pumpCurrent, 8'ha5);
  endtask
  // three bytes from 0x0f down, with masks and the calibrate bit
  task automatic tMulti;
    wr(13'hf, 2'h2, 32'hff85ff00);
    cmp8(oscLevel, 8'h80);
    upd();
    cmp8(oscLevel, 8'hfc);
    cmp8(backlashLock, 8'hc1);
    cmp8(oscCalControl, 8'h05);
    cmp8(8'(calCount), 8'h01);
  endtask
  task automatic tStreamRead;
    rd(13'hb, 2'h3, 4);
    cmp8(r[31:24], 8'h30);
    cmp8(r[23:16], 8'ha5);
    cmp8(r[15:0] == 16'h0, 8'h01);
  endtask
  task automatic tReadback;
    wr(13'h4, 2'h0, 32'h01000000);
    upd();
    wr(13'ha, 2'h0, 32'h3c000000);
    rd(13'ha, 2'h0, 1);
    cmp8(r[31:24], 8'h3c);
    cmp8(pumpCurrent, 8'ha5);
  endtask
  // lsb-first: address climbs per byte
  task automatic tLsbFirst;
    wr(13'h0, 2'h0, 32'h42000000);
    upd();
    cmp8({7'h0, lsbFirstActive}, 8'h01);
    lsbMode = 1'b1;
    wr(13'hb, 2'h1, 32'h31050000);
    upd();
    cmp8(pumpOptions, 8'h31);
    cmp8(pumpClockDiv, 8'h05);
  endtask
  task automatic tSoftReset;
    wr(13'h0, 2'h0, 32'h20000000);
    cmp8({7'h0, lsbFirstActive}, 8'h00);
    cmp8(pumpOptions ^ 8'h30 | pumpCurrent | pumpClockDiv, 8'h00);
    lsbMode = 1'b0;
    rd(13'ha, 2'h0, 1);
    cmp8(r[31:24], 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clock);
    failCount++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    lsbMode = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    tDefaults();
    tBuffered();
    tMulti();
    tStreamRead();
    tReadback();
    tLsbFirst();
    tSoftReset();
    tally_and_finish();
  end
endmodule
